/* File: verilog/twx_exec.sv */
// executor for table write, test-and-skip-if-zero and xor-literal
// assumes instructions offered at Q1, file data valid in Q3, wishbone host for registers
//
// Design decisions made here: register access over Wishbone and the register addresses.
module twx_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // instruction stream
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic next_two_word_i,
    // file register read
    input wire logic [7:0] file_data_i,
    output logic file_rd_o,
    output logic [twx_pkg::FILE_AW-1:0] file_addr_o,
    // pipeline control
    output logic busy_o,
    output logic skip_o,
    output logic nop_o,
    output logic [1:0] phase_o,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    typedef struct packed {
        twx_pkg::twx_state_t st;
        twx_pkg::twx_phase_t q;
        logic [15:0] op;
        logic [7:0] w;
        logic n;
        logic z;
        logic [twx_pkg::PTR_W-1:0] ptr;
        logic [7:0] latch;
        logic [7:0] tmp;
        logic [twx_pkg::BANK_W-1:0] bank_select_register;
        logic [twx_pkg::FILE_AW-1:0] idx;
        logic ext;
        logic zero;
        logic two_word;
        logic [twx_pkg::FILE_AW-1:0] faddr;
        logic frd;
        logic skip;
        logic no_operation_cycle;
        logic busy;
        logic ack;
        logic [31:0] rdat;
    } twx_exec_state_t;

    twx_exec_state_t r;
    twx_exec_state_t next_r;
    logic hold_we;
    logic [twx_pkg::HOLD_IW-1:0] hold_idx;
    logic [twx_pkg::HOLD_N*8-1:0] hold_bytes;
    logic take;
    logic bus_req;
    logic bus_wr;
    logic [31:0] wval;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [twx_pkg::FILE_AW-1:0] resolve(input logic [15:0] op,
        input logic [twx_pkg::BANK_W-1:0] bank_select_register, input logic ext,
        input logic [twx_pkg::FILE_AW-1:0] idx);
        logic [twx_pkg::FILE_AW-1:0] a;
        a = {bank_select_register, op[7:0]};
        if (!op[twx_pkg::ACC_BIT])
        begin
            if (ext && op[7:0] <= twx_pkg::INDEX_LIMIT)
            begin
                a = idx + {4'h0, op[7:0]};
            end
            else if (op[7:0] <= twx_pkg::INDEX_LIMIT)
            begin
                a = {twx_pkg::ACCESS_LO_PAGE, op[7:0]};
            end
            else
            begin
                a = {twx_pkg::ACCESS_HI_PAGE, op[7:0]};
            end
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign bus_req = cyc_i && stb_i && !r.ack;
    assign bus_wr = bus_req && we_i;
    assign take = (r.st == twx_pkg::ST_RUN) && (r.q == twx_pkg::PH_Q1) && instr_valid_i;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_r = r;
        hold_we = 1'b0;
        hold_idx = r.ptr[twx_pkg::HOLD_IW-1:0];
        wval = 32'h0000_0000;
        next_r.q = twx_pkg::twx_phase_t'(r.q + 2'h1);
        next_r.ack = bus_req;
        next_r.frd = 1'b0;
        next_r.skip = 1'b0;
        next_r.rdat = 32'h0000_0000;

        // registers for software; execution below overrides a same-edge write
        if (bus_req && !we_i)
        begin
            unique case (adr_i)
                twx_pkg::REG_CTRL: next_r.rdat[twx_pkg::CTRL_EXT_BIT] = r.ext;
                twx_pkg::REG_WORK: next_r.rdat[7:0] = r.w;
                twx_pkg::REG_STATUS:
                begin
                    next_r.rdat[twx_pkg::ST_Z_BIT] = r.z;
                    next_r.rdat[twx_pkg::ST_N_BIT] = r.n;
                end
                twx_pkg::REG_TPTR: next_r.rdat[twx_pkg::PTR_W-1:0] = r.ptr;
                twx_pkg::REG_TLATCH: next_r.rdat[7:0] = r.latch;
                twx_pkg::REG_BANK: next_r.rdat[twx_pkg::BANK_W-1:0] = r.bank_select_register;
                twx_pkg::REG_INDEX: next_r.rdat[twx_pkg::FILE_AW-1:0] = r.idx;
                twx_pkg::REG_EXEC:
                begin
                    next_r.rdat[twx_pkg::EX_BUSY_BIT] = r.busy;
                    next_r.rdat[twx_pkg::EX_NOP_BIT] = r.no_operation_cycle;
                end
                default:
                begin
                    if (adr_i[7:5] == twx_pkg::HOLD_WIN)
                    begin
                        next_r.rdat[7:0] = hold_bytes[adr_i[4:2]*8 +: 8];
                    end
                end
            endcase
        end
        if (bus_wr)
        begin
            unique case (adr_i)
                twx_pkg::REG_CTRL:
                begin
                    wval = merge({31'h0, r.ext}, dat_i, sel_i);
                    next_r.ext = wval[twx_pkg::CTRL_EXT_BIT];
                end
                twx_pkg::REG_WORK:
                begin
                    wval = merge({24'h0, r.w}, dat_i, sel_i);
                    next_r.w = wval[7:0];
                end
                twx_pkg::REG_STATUS:
                begin
                    wval = merge(32'h0, dat_i, sel_i);
                    next_r.z = sel_i[0] ? wval[twx_pkg::ST_Z_BIT] : r.z;
                    next_r.n = sel_i[0] ? wval[twx_pkg::ST_N_BIT] : r.n;
                end
                twx_pkg::REG_TPTR:
                begin
                    wval = merge({11'h0, r.ptr}, dat_i, sel_i);
                    next_r.ptr = wval[twx_pkg::PTR_W-1:0];
                end
                twx_pkg::REG_TLATCH:
                begin
                    wval = merge({24'h0, r.latch}, dat_i, sel_i);
                    next_r.latch = wval[7:0];
                end
                twx_pkg::REG_BANK:
                begin
                    wval = merge({28'h0, r.bank_select_register}, dat_i, sel_i);
                    next_r.bank_select_register = wval[twx_pkg::BANK_W-1:0];
                end
                twx_pkg::REG_INDEX:
                begin
                    wval = merge({20'h0, r.idx}, dat_i, sel_i);
                    next_r.idx = wval[twx_pkg::FILE_AW-1:0];
                end
                default: wval = 32'h0000_0000;
            endcase
        end

        unique case (r.st)
            twx_pkg::ST_RUN:
            begin
                if (take)
                begin
                    next_r.op = instr_i;
                    if ((instr_i & twx_pkg::TST_MASK) == twx_pkg::TST_CODE)
                    begin
                        next_r.frd = 1'b1;
                        next_r.faddr = resolve(instr_i, r.bank_select_register, r.ext, r.idx);
                    end
                end
                if (r.q == twx_pkg::PH_Q3 && (r.op & twx_pkg::TST_MASK) == twx_pkg::TST_CODE)
                begin
                    next_r.zero = (file_data_i == 8'h00);
                end
                if (r.q == twx_pkg::PH_Q4)
                begin
                    next_r.op = 16'h0000;
                    next_r.zero = 1'b0;
                    // xor into work, N and Z only
                    if ((r.op & twx_pkg::XOR_MASK) == twx_pkg::XOR_CODE)
                    begin
                        next_r.w = r.w ^ r.op[7:0];
                        next_r.z = ((r.w ^ r.op[7:0]) == 8'h00);
                        next_r.n = r.w[7] ^ r.op[7];
                    end
                    if ((r.op & twx_pkg::TW_MASK) == twx_pkg::TW_CODE)
                    begin
                        next_r.op = r.op;
                        next_r.st = twx_pkg::ST_TW2;
                    end
                    if ((r.op & twx_pkg::TST_MASK) == twx_pkg::TST_CODE && r.zero)
                    begin
                        next_r.st = twx_pkg::ST_SKIP1;
                        next_r.skip = 1'b1;
                        next_r.two_word = next_two_word_i;
                    end
                end
            end
            twx_pkg::ST_TW2:
            begin
                if (r.q == twx_pkg::PH_Q2)
                begin
                    next_r.tmp = r.latch;
                    if (r.op[1:0] == twx_pkg::TW_PREINC)
                    begin
                        next_r.ptr = r.ptr + 21'h000001;
                    end
                end
                if (r.q == twx_pkg::PH_Q4)
                begin
                    // low three pointer bits select the holding entry
                    hold_we = 1'b1;
                    // post modes adjust after the copy
                    unique case (twx_pkg::twx_tw_mode_t'(r.op[1:0]))
                        twx_pkg::TW_POSTINC: next_r.ptr = r.ptr + 21'h000001;
                        twx_pkg::TW_POSTDEC: next_r.ptr = r.ptr - 21'h000001;
                        twx_pkg::TW_KEEP, twx_pkg::TW_PREINC: next_r.ptr = r.ptr;
                    endcase
                    next_r.op = 16'h0000;
                    next_r.st = twx_pkg::ST_RUN;
                end
            end
            twx_pkg::ST_SKIP1:
            begin
                // two-word follower needs a second no-op
                if (r.q == twx_pkg::PH_Q4)
                begin
                    next_r.st = r.two_word ? twx_pkg::ST_SKIP2 : twx_pkg::ST_RUN;
                end
            end
            twx_pkg::ST_SKIP2:
            begin
                if (r.q == twx_pkg::PH_Q4)
                begin
                    next_r.st = twx_pkg::ST_RUN;
                end
            end
        endcase
        next_r.no_operation_cycle = (next_r.st == twx_pkg::ST_SKIP1) || (next_r.st == twx_pkg::ST_SKIP2);
        // busy covers the instruction from Q2 to its last Q4 so a new one waits for the next Q1
        next_r.busy = (next_r.st != twx_pkg::ST_RUN) || (next_r.op != 16'h0000);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            r.st <= twx_pkg::ST_RUN;
            r.q <= twx_pkg::PH_Q1;
            r.w <= twx_pkg::WORK_RST;
            r.ptr <= twx_pkg::TPTR_RST;
            r.bank_select_register <= twx_pkg::BANK_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // holding registers
    twx_hold_bank u_hold (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(hold_we),
        .idx_i(hold_idx),
        .data_i(r.tmp),
        .bytes_o(hold_bytes)
    );

    assign file_rd_o = r.frd;
    assign file_addr_o = r.faddr;
    assign busy_o = r.busy;
    assign skip_o = r.skip;
    assign nop_o = r.no_operation_cycle;
    assign phase_o = r.q;
    assign dat_o = r.rdat;
    assign ack_o = r.ack;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    tw_second_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && (instr_i & twx_pkg::TW_MASK) == twx_pkg::TW_CODE)
        |-> ##4 (r.st == twx_pkg::ST_TW2) ##4 (r.st == twx_pkg::ST_RUN))
        else $error("table write not two instruction cycles");

    tw_postinc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && instr_i == (twx_pkg::TW_CODE | 16'h0001) && !cyc_i)
        ##1 !cyc_i [*7] |=> (r.ptr == $past(r.ptr, 8) + 21'h000001))
        else $error("post-increment pointer wrong");

    hold_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hold_we |-> (r.st == twx_pkg::ST_TW2 && r.q == twx_pkg::PH_Q4
                     && hold_idx == r.ptr[twx_pkg::HOLD_IW-1:0])
        ##1 (hold_bytes[8 * $past(hold_idx) +: 8] == $past(r.tmp)))
        else $error("holding write index, phase or byte wrong");

    tw_no_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (r.st == twx_pkg::ST_TW2 && !bus_wr) |=> ($stable(r.z) && $stable(r.n)))
        else $error("table write touched flags");

    skip_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (r.st == twx_pkg::ST_RUN && r.q == twx_pkg::PH_Q3
         && (r.op & twx_pkg::TST_MASK) == twx_pkg::TST_CODE)
        |-> ##2 (skip_o == (($past(file_data_i, 2)) == 8'h00)))
        else $error("skip decision does not match operand");

    skip_two_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (skip_o && r.two_word) |-> nop_o [*8] ##1 !nop_o)
        else $error("two-word skip not two no-op cycles");

    read_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
        file_rd_o |-> (r.q == twx_pkg::PH_Q2) ##1 !file_rd_o)
        else $error("file read outside Q2");

    bank_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (file_rd_o && r.op[twx_pkg::ACC_BIT]) |-> (file_addr_o[11:8] == r.bank_select_register))
        else $error("bank select not used for operand");

    xor_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && (instr_i & twx_pkg::XOR_MASK) == twx_pkg::XOR_CODE && !cyc_i)
        ##1 !cyc_i [*3] |=> (r.w == ($past(r.w, 4) ^ $past(instr_i[7:0], 4))
                            && r.z == (r.w == 8'h00) && r.n == r.w[7]))
        else $error("xor literal result or flags wrong");

endmodule // twx_exec

/* File: verilog/twx_pkg.sv */
// constants, encodings and register map of the table-write / test-skip / xor executor
// assumes one 100 MHz clock, four clocks per instruction cycle, classic wishbone access
// Functional notes
// - two-bit mode: keep, postinc, postdec, preinc
// - post modes copy first; preinc bumps first
// - pointer low three bits pick holding register
// - pointer is 21 bits, byte addressed
// - holding bytes retained; table write flagless
// - zero operand discards next, runs no-op
// - two-word follower costs one more no-op
// - access bit 0 access bank, 1 bank register
// - access, extended, addr<=95 uses indexed offset
// - xor literal into work, only N and Z
package twx_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcode decode
    localparam logic [15:0] TW_MASK = 16'hFFFC;
    localparam logic [15:0] TW_CODE = 16'h000C;
    localparam logic [15:0] TST_MASK = 16'hFE00;
    localparam logic [15:0] TST_CODE = 16'h6600;
    localparam logic [15:0] XOR_MASK = 16'hFF00;
    localparam logic [15:0] XOR_CODE = 16'h0A00;
    localparam int ACC_BIT = 8;

    typedef enum logic [1:0] {
        TW_KEEP = 2'h0,
        TW_POSTINC = 2'h1,
        TW_POSTDEC = 2'h2,
        TW_PREINC = 2'h3
    } twx_tw_mode_t;

    // quadrature phase inside one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h2,
        PH_Q4 = 2'h3
    } twx_phase_t;

    // gray along run -> skip1 -> skip2, and run -> table write second cycle
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SKIP1 = 2'b01,
        ST_SKIP2 = 2'b11,
        ST_TW2 = 2'b10
    } twx_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int PTR_W = 21;
    localparam int HOLD_N = 8;
    localparam int HOLD_IW = 3;
    localparam int FILE_AW = 12;
    localparam int BANK_W = 4;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
    localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WORK = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TPTR = 8'h0C;
    localparam logic [7:0] REG_TLATCH = 8'h10;
    localparam logic [7:0] REG_BANK = 8'h14;
    localparam logic [7:0] REG_INDEX = 8'h18;
    localparam logic [7:0] REG_EXEC = 8'h1C;
    localparam logic [2:0] HOLD_WIN = 3'h1;
    localparam int CTRL_EXT_BIT = 0;
    localparam int ST_Z_BIT = 2;
    localparam int ST_N_BIT = 4;
    localparam int EX_BUSY_BIT = 0;
    localparam int EX_NOP_BIT = 1;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [PTR_W-1:0] TPTR_RST = 21'h000000;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

endpackage

/* File: verilog/twx_hold_bank.sv */
// eight program-memory holding registers with one write port
// assumes the executor drives one write strobe per table write
module twx_hold_bank #(
    parameter int N = twx_pkg::HOLD_N,
    parameter int IW = twx_pkg::HOLD_IW
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // write port
    input wire logic we_i,
    input wire logic [IW-1:0] idx_i,
    input wire logic [7:0] data_i,
    // all bytes
    output logic [N*8-1:0] bytes_o
);

    typedef struct packed {
        logic [N-1:0][7:0] b;
    } twx_hold_state_t;

    twx_hold_state_t r;
    twx_hold_state_t next_r;
    logic [N-1:0] hit;

    ////////////////////////////////////////////////////////////////////////////
    // one-hot entry select
    for (genvar i = 0; i < N; i++)
    begin : g_hit
        assign hit[i] = we_i && (idx_i == IW'(i));
        assign bytes_o[i*8 +: 8] = r.b[i];
    end

    // bytes only change on a hit
    always_comb
    begin
        next_r = r;
        for (int i = 0; i < N; i++)
        begin
            if (hit[i])
            begin
                next_r.b[i] = data_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // retention check
    hold_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !we_i |=> $stable(bytes_o))
        else $error("holding bytes changed without a write");

endmodule // twx_hold_bank

/* File: verification/twx_file_model.sv */
// file register space answering the executor's read port
// assumes one read pulse per test instruction, data sampled one clock later
module twx_file_model (
    // clock
    input wire logic clk_i,
    // read port
    input wire logic rd_i,
    input wire logic [twx_pkg::FILE_AW-1:0] addr_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [4096];

    initial data_o = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // answer ready for Q3
    // outside the read window the line toggles, so a sample one clock late never matches
    always @(posedge clk_i)
    begin
        if (rd_i)
            data_o <= mem[addr_i];
        else
            data_o <= ~data_o;
    end
endmodule // twx_file_model

/* File: verification/test_table_write_test_xor_exec.sv */
// self-checking bench for the table write / test-skip / xor executor
// assumes classic wishbone register access and the file model on the read port
module test_table_write_test_xor_exec;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic next_two_word_i = 1'b0;
    logic [7:0] file_data_i;
    logic file_rd_o;
    logic [11:0] file_addr_o;
    logic busy_o;
    logic skip_o;
    logic nop_o;
    logic [1:0] phase_o;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    int errors = 0;
    int checked = 0;
    int busy_cnt, nop_cnt, skip_cnt, rd_cnt;
    logic [31:0] q;
    logic [20:0] ptr;
    logic [7:0] hold [8];
    logic [7:0] stat, latch, f, fv, w, k, r;
    logic [11:0] ix, fa;
    logic [3:0] bk;
    logic [2:0] sidx;
    logic [1:0] md;
    logic a, ext, tw, zero;

    always #5 clk_i = ~clk_i;

    twx_exec i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .next_two_word_i(next_two_word_i), .file_data_i(file_data_i),
        .file_rd_o(file_rd_o), .file_addr_o(file_addr_o), .busy_o(busy_o),
        .skip_o(skip_o), .nop_o(nop_o), .phase_o(phase_o), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o)
    );

    twx_file_model i_file (
        .clk_i(clk_i), .rd_i(file_rd_o), .addr_i(file_addr_o), .data_o(file_data_i)
    );

    // pre-edge samples, so counts never race the design's own updates
    always @(posedge clk_i)
    begin
        busy_cnt += int'(busy_o === 1'b1);
        nop_cnt += int'(nop_o === 1'b1);
        skip_cnt += int'(skip_o === 1'b1);
        rd_cnt += int'(file_rd_o === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // bounded wait; a hang counts as a mismatch
    task automatic await(ref logic s, input logic v);
        int n;
        n = 0;
        @(posedge clk_i);
        while (s !== v && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n < 200), 32'h1, "handshake wait");
    endtask

    task automatic wb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= ad;
        sel_i <= 4'hF;
        dat_i <= d;
        await(ack_o, 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input string what);
        wb(1'b0, ad, 32'h00000000);
        check(q, e, what);
    endtask

    // offer one instruction and wait until it has run out
    task automatic run(input logic [15:0] op, input logic two);
        busy_cnt = 0;
        nop_cnt = 0;
        skip_cnt = 0;
        rd_cnt = 0;
        instr_valid_i <= 1'b1;
        instr_i <= op;
        next_two_word_i <= two;
        await(busy_o, 1'b1);
        check({30'h0, phase_o}, 32'h1, "phase after take");
        instr_valid_i <= 1'b0;
        await(busy_o, 1'b0);
    endtask

    function automatic logic [11:0] exp_addr(logic aa, logic ee, logic [3:0] b,
                                             logic [11:0] x, logic [7:0] ff);
        if (aa)
            return {b, ff};
        if (ee && ff <= 8'h5F)
            return x + {4'h0, ff};
        return (ff <= 8'h5F) ? {4'h0, ff} : {4'hF, ff};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        errors++;
        $display("unexpected at %0t: watchdog", $time);
        conclude();
    end

    initial
    begin
        void'($urandom(21701));
        stat = 8'h00;
        hold = '{default: 8'h00};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // read-only and unmapped writes must leave no trace
        wb(1'b1, twx_pkg::REG_EXEC, 32'hFFFFFFFF);
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        for (int i = 0; i < 17; i++)
            if (i != 4)
                rd_chk(8'(4 * i), 32'h00000000, "reset value");
        $display("test reset done");

        for (int i = 0; i < 24; i++)
        begin
            md = 2'((i + 2) % 4);
            ptr = (i == 0) ? 21'h000000 : (i == 1) ? 21'h1FFFFF : 21'($urandom);
            latch = 8'($urandom);
            wb(1'b1, twx_pkg::REG_TPTR, {11'h000, ptr});
            wb(1'b1, twx_pkg::REG_TLATCH, {24'h000000, latch});
            run({14'h0003, md}, 1'b0);
            if (md == 2'h3)
                ptr = ptr + 21'h1;
            sidx = ptr[2:0];
            hold[sidx] = latch;
            if (md == 2'h1)
                ptr = ptr + 21'h1;
            if (md == 2'h2)
                ptr = ptr - 21'h1;
            check(busy_cnt, 7, "table write length");
            rd_chk(twx_pkg::REG_TPTR, {11'h000, ptr}, "pointer");
            rd_chk({twx_pkg::HOLD_WIN, sidx, 2'h0}, {24'h0, latch}, "holding");
            rd_chk(twx_pkg::REG_STATUS, {24'h0, stat}, "flags kept");
        end
        for (int s = 0; s < 8; s++)
            rd_chk({twx_pkg::HOLD_WIN, 3'(s), 2'h0}, {24'h0, hold[s]}, "retained");
        $display("test table write done");

        for (int i = 0; i < 24; i++)
        begin
            a = (i < 2) ? 1'b0 : 1'($urandom);
            ext = (i < 2) ? 1'b1 : 1'($urandom);
            f = (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : 8'($urandom);
            bk = 4'($urandom);
            ix = 12'($urandom);
            tw = 1'($urandom);
            zero = i[1];
            wb(1'b1, twx_pkg::REG_CTRL, {31'h0, ext});
            wb(1'b1, twx_pkg::REG_BANK, {28'h0, bk});
            wb(1'b1, twx_pkg::REG_INDEX, {20'h0, ix});
            fa = exp_addr(a, ext, bk, ix, f);
            fv = zero ? 8'h00 : (8'($urandom) | 8'h01);
            i_file.mem[fa] = fv;
            run({7'h33, a, f}, tw);
            check({20'h0, file_addr_o}, {20'h0, fa}, "operand address");
            check(rd_cnt, 1, "file read");
            check(skip_cnt, zero ? 1 : 0, "skip pulse");
            check(nop_cnt, zero ? (tw ? 8 : 4) : 0, "no-op clocks");
            check(busy_cnt, zero ? (tw ? 11 : 7) : 3, "test length");
            rd_chk(twx_pkg::REG_STATUS, {24'h0, stat}, "flags kept");
        end
        $display("test skip done");

        for (int i = 0; i < 32; i++)
        begin
            w = 8'($urandom);
            k = (i == 0) ? w : 8'($urandom);
            wb(1'b1, twx_pkg::REG_WORK, {24'h0, w});
            run({8'h0A, k}, 1'b0);
            r = w ^ k;
            stat = {3'h0, r[7], 1'b0, r == 8'h00, 2'h0};
            check(busy_cnt, 3, "xor length");
            rd_chk(twx_pkg::REG_WORK, {24'h0, r}, "work");
            rd_chk(twx_pkg::REG_STATUS, {24'h0, stat}, "xor flags");
        end
        $display("test xor done");
        conclude();
    end
endmodule // test_table_write_test_xor_exec
